/* File: hdl/timer_protect_pkg.sv */
// offsets, field positions and reset values of the output-protection and burst slice
package timer_protect_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int SYNC_STAGES = 3;

   localparam logic [7:0] OFS_CTRL1 = 8'h00;
   localparam logic [7:0] OFS_BDTR = 8'h44;
   localparam logic [7:0] OFS_DCR = 8'h48;
   localparam logic [7:0] OFS_DMAR = 8'h4C;
   localparam logic [7:0] OFS_CHEN = 8'h50;
   localparam logic [7:0] OFS_CHMODE = 8'h54;
   localparam logic [7:0] OFS_IDLE = 8'h58;

   localparam logic [15:0] BDTR_RESET = 16'h0000;
   localparam logic [15:0] DCR_RESET = 16'h0000;

   localparam int BIT_MOE = 15;
   localparam int BIT_AOE = 14;
   localparam int BIT_BKP = 13;
   localparam int BIT_BKE = 12;
   localparam int BIT_RUN_OFF_STATE_SELECT = 11;
   localparam int BIT_IDLE_OFF_STATE_SELECT = 10;
   localparam int LOCK_LSB = 8;
   localparam int DTG_LSB = 0;
   localparam int DBL_LSB = 8;
   localparam int DBA_LSB = 0;

   localparam logic [1:0] LOCK_OFF = 2'h0;
   localparam logic [1:0] LOCK_L2 = 2'h2;
   localparam logic [1:0] LOCK_L3 = 2'h3;

   // channel registers, at most four channels
   localparam int CHEN_EN_LSB = 0;
   localparam int CHEN_NEN_LSB = 4;
   localparam int CHEN_P_LSB = 8;
   localparam int CHEN_NP_LSB = 12;
   localparam int IDLE_OIS_LSB = 0;
   localparam int IDLE_OISN_LSB = 4;
   localparam int MODE_DIR_LSB = 0;
   localparam int MODE_OCM_LSB = 8;
   localparam int MODE_STRIDE = 4;
   localparam int MODE_PE_OFS = 3;
   localparam logic [1:0] DIR_OUTPUT = 2'h0;

   // dead-time coding, in dead-time clock periods (one mclk period)
   localparam int DT_W = 11;
   localparam int DT_BASE_MID = 64;
   localparam int DT_MUL_MID = 2;
   localparam int DT_BASE_LONG = 32;
   localparam int DT_MUL_LONG = 8;
   localparam int DT_MUL_MAX = 16;
endpackage

/* File: hdl/timer_protect.sv */
// break, off-state, lock, dead-time and dma burst window of a motor-control timer
// How it works
// - break clears main output enable asynchronously
// - auto enable sets main enable at update
// - main enable low idles all channel outputs
// - polarity bit picks break active level
// - break enable gates both break inputs
// - run off-state: disable or drive inactive
// - idle off-state: disable or drive idle
// - lock one freezes dead-time, idle, break bits
// - lock two also freezes off-state, polarity
// - lock three also freezes compare mode
// - lock field writable once after reset
// - dead-time between normal and complement output
// - dead-time codes 0xx and 10x
// - dead-time codes 110 and 111
// - burst length field plus one transfers
// - window register access is one burst element
// - burst base counts from control register one
// - window redirects to base plus index
// - burst control reserved bits read zero
// - each transfer carries one register in a 32-bit data word
`timescale 1ns/10ps
module timer_protect #(
   parameter int NCH = 3
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [timer_protect_pkg::ADDR_W-1:0] paddr,
   input wire logic [timer_protect_pkg::DATA_W-1:0] pwdata,
   output logic [timer_protect_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic break_input,
   input wire logic break_input_high_active,
   input wire logic update_event,
   input wire logic [NCH-1:0] compare_ref,
   output logic [NCH-1:0] channel_out,
   output logic [NCH-1:0] channel_out_en,
   output logic [NCH-1:0] channel_out_complement,
   output logic [NCH-1:0] channel_out_complement_en,
   output logic [3*NCH-1:0] compare_output_mode,
   output logic [NCH-1:0] compare_preload_enable,
   output logic main_output_enable
);
   import timer_protect_pkg::*;

   logic moe_reg;
   logic aoe_reg, bkp_reg, bke_reg, run_off_state_select_reg, idle_off_state_select_reg, lock_done_reg;
   logic [1:0] lock_reg;
   logic [7:0] dtg_reg;
   logic [4:0] blen_reg, bbase_reg, bidx_reg;
   logic [NCH-1:0] cce_reg, ccne_reg, ccp_reg, ccnp_reg, ois_reg, oisn_reg, ocpe_reg;
   logic [2*NCH-1:0] dir_reg;
   logic [3*NCH-1:0] ocm_reg;
   logic pready_reg, pslverr_reg;
   logic [DATA_W-1:0] prdata_reg, rd_word;
   logic [NCH-1:0] oc_reg, oce_reg, ocn_reg, ocne_reg;

   // ---------------- apb slave ----------------
   logic access, commit, is_window, wr, wr_bdtr, wr_dcr, wr_chen, wr_chmode, wr_idle, mapped;
   logic [5:0] target_idx;
   logic [ADDR_W-1:0] eff_addr;

   assign access = psel & penable;
   assign commit = access & pready_reg;
   assign is_window = (paddr == OFS_DMAR);
   assign target_idx = {1'b0, bbase_reg} + {1'b0, bidx_reg};
   // the window can point at itself (base plus index 19), but it is redirected only once, so no recursion
   assign eff_addr = is_window ? (OFS_CTRL1 + {target_idx, 2'b00}) : paddr;
   assign wr = commit & pwrite;
   assign wr_bdtr = wr && (eff_addr == OFS_BDTR);
   assign wr_dcr = wr && (eff_addr == OFS_DCR);
   assign wr_chen = wr && (eff_addr == OFS_CHEN);
   assign wr_chmode = wr && (eff_addr == OFS_CHMODE);
   assign wr_idle = wr && (eff_addr == OFS_IDLE);
   assign mapped = (paddr == OFS_BDTR) || (paddr == OFS_DCR) || (paddr == OFS_DMAR) ||
                   (paddr == OFS_CHEN) || (paddr == OFS_CHMODE) || (paddr == OFS_IDLE);

   always_comb begin
      rd_word = '0;
      case (eff_addr)
         OFS_BDTR: begin
            rd_word[BIT_MOE] = moe_reg;
            rd_word[BIT_AOE] = aoe_reg;
            rd_word[BIT_BKP] = bkp_reg;
            rd_word[BIT_BKE] = bke_reg;
            rd_word[BIT_RUN_OFF_STATE_SELECT] = run_off_state_select_reg;
            rd_word[BIT_IDLE_OFF_STATE_SELECT] = idle_off_state_select_reg;
            rd_word[LOCK_LSB +: 2] = lock_reg;
            rd_word[DTG_LSB +: 8] = dtg_reg;
         end
         OFS_DCR: begin
            // everything else stays zero, reserved bits included
            rd_word[DBL_LSB +: 5] = blen_reg;
            rd_word[DBA_LSB +: 5] = bbase_reg;
         end
         OFS_CHEN: begin
            rd_word[CHEN_EN_LSB +: NCH] = cce_reg;
            rd_word[CHEN_NEN_LSB +: NCH] = ccne_reg;
            rd_word[CHEN_P_LSB +: NCH] = ccp_reg;
            rd_word[CHEN_NP_LSB +: NCH] = ccnp_reg;
         end
         OFS_CHMODE: begin
            for (int i = 0; i < NCH; i++) begin
               rd_word[MODE_DIR_LSB + 2*i +: 2] = dir_reg[2*i +: 2];
               rd_word[MODE_OCM_LSB + MODE_STRIDE*i +: 3] = ocm_reg[3*i +: 3];
               rd_word[MODE_OCM_LSB + MODE_STRIDE*i + MODE_PE_OFS] = ocpe_reg[i];
            end
         end
         OFS_IDLE: begin
            rd_word[IDLE_OIS_LSB +: NCH] = ois_reg;
            rd_word[IDLE_OISN_LSB +: NCH] = oisn_reg;
         end
         default: rd_word = '0;
      endcase
   end

   // one wait state: pready rises in the second access cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= '0;
      end else begin
         pready_reg <= access & ~pready_reg;
         pslverr_reg <= access & ~pready_reg & ~mapped;
         prdata_reg <= (access & ~pready_reg & ~pwrite) ? rd_word : '0;
      end
   end

   // ---------------- break inputs ----------------
   logic [SYNC_STAGES-1:0] brk_sync [2];
   logic [1:0] brk_stable;
   logic [1:0] brk_pins;
   logic brk_async, brk_active;

   assign brk_pins = {break_input_high_active, break_input};

   for (genvar b = 0; b < 2; b++) begin : g_brk_sync
      always_ff @(posedge mclk) begin
         if (rst) begin
            brk_sync[b] <= '0;
            brk_stable[b] <= 1'b0;
         end else begin
            brk_sync[b] <= {brk_sync[b][SYNC_STAGES-2:0], brk_pins[b]};
            if (brk_sync[b][1] == brk_sync[b][2]) begin
               brk_stable[b] <= brk_sync[b][2];
            end
         end
      end
   end

   // raw pin path clears the enable with no clock; synced path blocks auto set
   assign brk_async = bke_reg & ((break_input == bkp_reg) | break_input_high_active);
   assign brk_active = bke_reg & ((brk_stable[0] == bkp_reg) | brk_stable[1]);

   // a glitch on the break pin will also clear the enable; that is the intent
   always_ff @(posedge mclk or posedge brk_async) begin
      if (brk_async) begin
         moe_reg <= 1'b0;
      end else if (rst) begin
         moe_reg <= BDTR_RESET[BIT_MOE];
      end else if (wr_bdtr) begin
         moe_reg <= pwdata[BIT_MOE];
      end else if (aoe_reg && update_event && !brk_active) begin
         moe_reg <= 1'b1;
      end
   end

   // ---------------- break and dead-time configuration ----------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         aoe_reg <= BDTR_RESET[BIT_AOE];
         bkp_reg <= BDTR_RESET[BIT_BKP];
         bke_reg <= BDTR_RESET[BIT_BKE];
         run_off_state_select_reg <= BDTR_RESET[BIT_RUN_OFF_STATE_SELECT];
         idle_off_state_select_reg <= BDTR_RESET[BIT_IDLE_OFF_STATE_SELECT];
         lock_reg <= BDTR_RESET[LOCK_LSB +: 2];
         dtg_reg <= BDTR_RESET[DTG_LSB +: 8];
         lock_done_reg <= 1'b0;
      end else if (wr_bdtr) begin
         // old lock level applies, so one first write programs everything
         if (lock_reg == LOCK_OFF) begin
            aoe_reg <= pwdata[BIT_AOE];
            bkp_reg <= pwdata[BIT_BKP];
            bke_reg <= pwdata[BIT_BKE];
            dtg_reg <= pwdata[DTG_LSB +: 8];
         end
         if (lock_reg < LOCK_L2) begin
            run_off_state_select_reg <= pwdata[BIT_RUN_OFF_STATE_SELECT];
            idle_off_state_select_reg <= pwdata[BIT_IDLE_OFF_STATE_SELECT];
         end
         if (!lock_done_reg) begin
            lock_reg <= pwdata[LOCK_LSB +: 2];
         end
         lock_done_reg <= 1'b1;
      end
   end

   // ---------------- burst control ----------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         blen_reg <= DCR_RESET[DBL_LSB +: 5];
         bbase_reg <= DCR_RESET[DBA_LSB +: 5];
      end else if (wr_dcr) begin
         blen_reg <= pwdata[DBL_LSB +: 5];
         bbase_reg <= pwdata[DBA_LSB +: 5];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || wr_dcr) begin
         bidx_reg <= '0;
      end else if (commit && is_window) begin
         bidx_reg <= (bidx_reg == blen_reg) ? 5'h00 : bidx_reg + 5'h01;
      end
   end

   // ---------------- dead-time length ----------------
   logic [DT_W-1:0] dt_cyc;

   always_comb begin
      dt_cyc = '0;
      if (!dtg_reg[7]) begin
         dt_cyc = {3'h0, dtg_reg};
      end else if (!dtg_reg[6]) begin
         dt_cyc = DT_W'((DT_BASE_MID + int'(dtg_reg[5:0])) * DT_MUL_MID);
      end else if (!dtg_reg[5]) begin
         dt_cyc = DT_W'((DT_BASE_LONG + int'(dtg_reg[4:0])) * DT_MUL_LONG);
      end else begin
         dt_cyc = DT_W'((DT_BASE_LONG + int'(dtg_reg[4:0])) * DT_MUL_MAX);
      end
   end

   // ---------------- per channel ----------------
   logic [NCH-1:0] oc_raw, ocn_raw;

   always_ff @(posedge mclk) begin
      if (rst) begin
         cce_reg <= '0;
         ccne_reg <= '0;
      end else if (wr_chen) begin
         cce_reg <= pwdata[CHEN_EN_LSB +: NCH];
         ccne_reg <= pwdata[CHEN_NEN_LSB +: NCH];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ois_reg <= '0;
         oisn_reg <= '0;
      end else if (wr_idle && lock_reg == LOCK_OFF) begin
         ois_reg <= pwdata[IDLE_OIS_LSB +: NCH];
         oisn_reg <= pwdata[IDLE_OISN_LSB +: NCH];
      end
   end

   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic is_out, ref_q, settled, oc_n, oce_n, ocn_n, ocne_n;
      logic [DT_W-1:0] dt_cnt;

      assign is_out = (dir_reg[2*c +: 2] == DIR_OUTPUT);

      always_ff @(posedge mclk) begin
         if (rst) begin
            dir_reg[2*c +: 2] <= DIR_OUTPUT;
         end else if (wr_chmode) begin
            dir_reg[2*c +: 2] <= pwdata[MODE_DIR_LSB + 2*c +: 2];
         end
      end

      // input channels stay writable at every lock level
      always_ff @(posedge mclk) begin
         if (rst) begin
            ccp_reg[c] <= 1'b0;
            ccnp_reg[c] <= 1'b0;
         end else if (wr_chen && !(is_out && lock_reg >= LOCK_L2)) begin
            ccp_reg[c] <= pwdata[CHEN_P_LSB + c];
            ccnp_reg[c] <= pwdata[CHEN_NP_LSB + c];
         end
      end

      always_ff @(posedge mclk) begin
         if (rst) begin
            ocm_reg[3*c +: 3] <= 3'h0;
            ocpe_reg[c] <= 1'b0;
         end else if (wr_chmode && !(is_out && lock_reg == LOCK_L3)) begin
            ocm_reg[3*c +: 3] <= pwdata[MODE_OCM_LSB + MODE_STRIDE*c +: 3];
            ocpe_reg[c] <= pwdata[MODE_OCM_LSB + MODE_STRIDE*c + MODE_PE_OFS];
         end
      end

      // a reference edge restarts the count; the edge cycle is the first period
      always_ff @(posedge mclk) begin
         if (rst) begin
            ref_q <= 1'b0;
            dt_cnt <= '0;
         end else begin
            ref_q <= compare_ref[c];
            if (compare_ref[c] != ref_q) begin
               dt_cnt <= (dt_cyc != '0) ? dt_cyc - 1'b1 : '0;
            end else if (dt_cnt != '0) begin
               dt_cnt <= dt_cnt - 1'b1;
            end
         end
      end

      assign settled = (compare_ref[c] == ref_q) ? (dt_cnt == '0) : (dt_cyc == '0);
      assign oc_raw[c] = compare_ref[c] & settled;
      assign ocn_raw[c] = ~compare_ref[c] & settled;

      always_comb begin
         oc_n = ccp_reg[c];
         ocn_n = ccnp_reg[c];
         oce_n = 1'b0;
         ocne_n = 1'b0;
         if (!is_out) begin
            oce_n = 1'b0;
         end else if (moe_reg) begin
            if (cce_reg[c]) begin
               oce_n = 1'b1;
               oc_n = oc_raw[c] ^ ccp_reg[c];
            end else begin
               oce_n = run_off_state_select_reg & ccne_reg[c];
            end
            if (ccne_reg[c]) begin
               ocne_n = 1'b1;
               ocn_n = ocn_raw[c] ^ ccnp_reg[c];
            end else begin
               ocne_n = run_off_state_select_reg & cce_reg[c];
            end
         end else begin
            oc_n = ois_reg[c];
            ocn_n = oisn_reg[c];
            oce_n = idle_off_state_select_reg & (cce_reg[c] | ccne_reg[c]);
            ocne_n = idle_off_state_select_reg & (cce_reg[c] | ccne_reg[c]);
         end
      end

      always_ff @(posedge mclk) begin
         if (rst) begin
            oc_reg[c] <= 1'b0;
            oce_reg[c] <= 1'b0;
            ocn_reg[c] <= 1'b0;
            ocne_reg[c] <= 1'b0;
         end else begin
            oc_reg[c] <= oc_n;
            oce_reg[c] <= oce_n;
            ocn_reg[c] <= ocn_n;
            ocne_reg[c] <= ocne_n;
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign channel_out = oc_reg;
   assign channel_out_en = oce_reg;
   assign channel_out_complement = ocn_reg;
   assign channel_out_complement_en = ocne_reg;
   assign compare_output_mode = ocm_reg;
   assign compare_preload_enable = ocpe_reg;
   assign main_output_enable = moe_reg;

   // ---------------- checks ----------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_break_clears_moe: assert property (brk_active && brk_async |-> !moe_reg)
      else $error("main output enable set during break");
   a_auto_set_moe: assert property (aoe_reg && update_event && !brk_active && !brk_async && !wr_bdtr
      |=> moe_reg || brk_async)
      else $error("auto enable did not set main output enable");
   a_no_auto_moe: assert property (!aoe_reg && !moe_reg && !wr_bdtr |=> !moe_reg)
      else $error("main output enable set without software");
   a_idle_disable: assert property (!moe_reg && !idle_off_state_select_reg |=> channel_out_en == '0 &&
      channel_out_complement_en == '0)
      else $error("output enabled in idle with idle off-state clear");
   a_run_disable: assert property (moe_reg && !run_off_state_select_reg && !cce_reg[0] |=> !channel_out_en[0])
      else $error("channel driven in run with channel disabled");
   a_lock_dtg: assert property (wr_bdtr && lock_reg != LOCK_OFF |=> $stable(dtg_reg) && $stable(bke_reg))
      else $error("locked dead-time or break bits changed");
   a_lock_offstate: assert property (wr_bdtr && lock_reg >= LOCK_L2 |=> $stable(run_off_state_select_reg) && $stable(idle_off_state_select_reg))
      else $error("locked off-state bits changed");
   a_lock_once: assert property (lock_done_reg |=> $stable(lock_reg))
      else $error("lock field changed after first write");
   a_dcr_reserved: assert property (pready_reg && !pwrite && eff_addr == OFS_DCR |->
      prdata_reg[15:13] == 3'h0 && prdata_reg[7:5] == 3'h0)
      else $error("reserved burst control bits read nonzero");
   a_index_wrap: assert property (commit && is_window && !wr_dcr && bidx_reg == blen_reg |=> bidx_reg == 5'h00)
      else $error("burst index did not wrap");
   a_index_step: assert property (commit && is_window && bidx_reg != blen_reg |=>
      bidx_reg == $past(bidx_reg) + 5'h01)
      else $error("burst index did not advance");
   a_deadtime_gap: assert property ($rose(compare_ref[0]) && dt_cyc == 11'h005 && $stable(dtg_reg)
      |-> !oc_raw[0] [*5] ##1 (oc_raw[0] || !compare_ref[0]))
      else $error("normal output rose inside dead-time");

endmodule // timer_protect

/* File: dv/apb_host_model.sv */
// bus host model: software and dma controller transfers on the register bus
`timescale 1ns/10ps
module apb_host_model (
   input wire logic mclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [timer_protect_pkg::ADDR_W-1:0] paddr,
   output logic [timer_protect_pkg::DATA_W-1:0] pwdata,
   input wire logic [timer_protect_pkg::DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   import timer_protect_pkg::*;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
   end
   // one whole 16-bit value per register and transfer
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
                       output logic [31:0] rd, output logic err);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge mclk);
      penable <= 1'b1;
      // no cycle limit here: only the bench watchdog ends a hung wait
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines must not look held
      pwrite <= ~wr;
      paddr <= ~a;
      pwdata <= ~{16'h0000, d};
   endtask
endmodule // apb_host_model

/* File: dv/timer_break_deadtime_dma_burst_tb.sv */
// self-checking bench for break, lock, dead-time and burst window
`timescale 1ns/10ps
module timer_break_deadtime_dma_burst_tb;
   import timer_protect_pkg::*;
   typedef struct packed {
      logic wr;
      logic [7:0] a;
      logic [15:0] d;
      logic [15:0] e;
      logic err;
   } row_t;
   logic mclk, rst, psel, penable, pwrite, pready, pslverr, main_output_enable;
   logic break_input, break_input_high_active, update_event;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0] compare_ref, channel_out, channel_out_en, channel_out_complement, channel_out_complement_en;
   logic [2:0] compare_preload_enable;
   logic [8:0] compare_output_mode;
   int errors, num_checks, r, f, r0, f0;
   logic [7:0] dts [5] = '{8'h00, 8'h05, 8'h81, 8'hC2, 8'hE1};
   row_t rows [23] = '{
      {1'b0, 8'h44, 16'h0000, 16'h0000, 1'b0}, {1'b0, 8'h48, 16'h0000, 16'h0000, 1'b0},
      {1'b0, 8'h4C, 16'h0000, 16'h0000, 1'b0}, {1'b1, 8'h48, 16'hFFFF, 16'h0000, 1'b0},
      {1'b0, 8'h48, 16'h0000, 16'h1F1F, 1'b0}, {1'b1, 8'h50, 16'h0011, 16'h0000, 1'b0},
      {1'b1, 8'h58, 16'h0001, 16'h0000, 1'b0}, {1'b1, 8'h44, 16'hDD05, 16'h0000, 1'b0},
      {1'b0, 8'h44, 16'h0000, 16'hDD05, 1'b0}, {1'b1, 8'h44, 16'h0EFF, 16'h0000, 1'b0},
      {1'b0, 8'h44, 16'h0000, 16'h5D05, 1'b0}, {1'b1, 8'h58, 16'h0000, 16'h0000, 1'b0},
      {1'b0, 8'h58, 16'h0000, 16'h0001, 1'b0}, {1'b1, 8'h60, 16'h1234, 16'h0000, 1'b1},
      {1'b0, 8'h60, 16'h0000, 16'h0000, 1'b1}, {1'b1, 8'h48, 16'h0214, 16'h0000, 1'b0},
      {1'b0, 8'h4C, 16'h0000, 16'h0011, 1'b0}, {1'b0, 8'h4C, 16'h0000, 16'h0000, 1'b0},
      {1'b0, 8'h4C, 16'h0000, 16'h0001, 1'b0}, {1'b0, 8'h4C, 16'h0000, 16'h0011, 1'b0},
      {1'b1, 8'h48, 16'h0214, 16'h0000, 1'b0}, {1'b1, 8'h4C, 16'h0033, 16'h0000, 1'b0},
      {1'b0, 8'h50, 16'h0000, 16'h0033, 1'b0}};

   apb_host_model i_host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   timer_protect i_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .break_input(break_input), .break_input_high_active(break_input_high_active),
      .update_event(update_event), .compare_ref(compare_ref), .channel_out(channel_out),
      .channel_out_en(channel_out_en), .channel_out_complement(channel_out_complement),
      .channel_out_complement_en(channel_out_complement_en), .compare_output_mode(compare_output_mode),
      .compare_preload_enable(compare_preload_enable), .main_output_enable(main_output_enable));

   task automatic complete_run;
      if (errors == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic [15:0] e,
                      input logic err_e);
      logic [31:0] rd;
      logic err;
      i_host.xfer(wr, a, d, rd, err);
      chk({31'h0, err}, {31'h0, err_e});
      if (!wr) begin
         chk(rd, {16'h0000, e});
      end
   endtask
   task automatic upd;
      @(posedge mclk);
      update_event <= 1'b1;
      @(posedge mclk);
      update_event <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask
   task automatic rst_do;
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask
   // delays from reference edge to active output, baseline removed later
   task automatic meas(output int rr, output int ff);
      rr = 0;
      ff = 0;
      @(posedge mclk);
      compare_ref <= 3'h1;
      do begin
         @(posedge mclk);
         rr++;
      end while (channel_out[0] !== 1'b1 && rr < 700);
      repeat (600) @(posedge mclk);
      compare_ref <= 3'h0;
      do begin
         @(posedge mclk);
         ff++;
      end while (channel_out_complement[0] !== 1'b1 && ff < 700);
      repeat (600) @(posedge mclk);
   endtask
   function automatic int dt_exp(input logic [7:0] d);
      if (!d[7]) return int'(d);
      if (!d[6]) return (DT_BASE_MID + int'(d[5:0])) * DT_MUL_MID;
      if (!d[5]) return (DT_BASE_LONG + int'(d[4:0])) * DT_MUL_LONG;
      return (DT_BASE_LONG + int'(d[4:0])) * DT_MUL_MAX;
   endfunction

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      repeat (60000) @(posedge mclk);
      errors++;
      complete_run;
   end
   initial begin
      rst = 1'b1;
      break_input = 1'b1;
      break_input_high_active = 1'b0;
      update_event = 1'b0;
      compare_ref = 3'h0;
      errors = 0;
      num_checks = 0;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      chk({28'h0, main_output_enable, channel_out_en}, 32'h0);
      foreach (rows[i]) acc(rows[i].wr, rows[i].a, rows[i].d, rows[i].e, rows[i].err);
      upd;
      chk({31'h0, main_output_enable}, 32'h1);
      chk({30'h0, channel_out_en[0], channel_out_en[2]}, 32'h2);
      @(posedge mclk);
      break_input <= 1'b0;
      #1 chk({31'h0, main_output_enable}, 32'h0);
      upd;
      chk({31'h0, main_output_enable}, 32'h0);
      chk({28'h0, channel_out[0], channel_out_en[0], channel_out_complement[0], channel_out_complement_en[0]},
          32'hD);
      break_input <= 1'b1;
      repeat (4) @(posedge mclk);
      upd;
      chk({31'h0, main_output_enable}, 32'h1);
      acc(1'b1, 8'h50, 16'h0001, 16'h0000, 1'b0);
      repeat (2) @(posedge mclk);
      chk({30'h0, channel_out_complement[0], channel_out_complement_en[0]}, 32'h1);
      acc(1'b1, 8'h48, 16'h1114, 16'h0000, 1'b0);
      for (int i = 0; i < 19; i++) begin
         acc(1'b0, 8'h4C, 16'h0000, (i % 18 == 0 || i == 2) ? 16'h0001 : 16'h0000, 1'b0);
      end
      rst_do;
      chk({28'h0, main_output_enable, channel_out_en}, 32'h0);
      acc(1'b1, 8'h50, 16'h0011, 16'h0000, 1'b0);
      for (int i = 0; i < 5; i++) begin
         acc(1'b1, 8'h44, {8'h80, dts[i]}, 16'h0000, 1'b0);
         repeat (600) @(posedge mclk);
         meas(r, f);
         if (i == 0) begin
            r0 = r;
            f0 = f;
         end else begin
            chk(32'(r - r0), 32'(dt_exp(dts[i])));
            chk(32'(f - f0), 32'(dt_exp(dts[i])));
         end
      end
      @(posedge mclk);
      break_input <= 1'b0;
      acc(1'b1, 8'h44, 16'hB000, 16'h0000, 1'b0);
      repeat (4) @(posedge mclk);
      chk({31'h0, main_output_enable}, 32'h1);
      break_input <= 1'b1;
      #1 chk({31'h0, main_output_enable}, 32'h0);
      @(posedge mclk);
      break_input <= 1'b0;
      acc(1'b1, 8'h44, 16'h8000, 16'h0000, 1'b0);
      break_input <= 1'b1;
      break_input_high_active <= 1'b1;
      repeat (4) @(posedge mclk);
      chk({31'h0, main_output_enable}, 32'h1);
      acc(1'b1, 8'h44, 16'h9000, 16'h0000, 1'b0);
      repeat (2) @(posedge mclk);
      chk({31'h0, main_output_enable}, 32'h0);
      break_input_high_active <= 1'b0;
      rst_do;
      acc(1'b1, 8'h44, 16'h0300, 16'h0000, 1'b0);
      acc(1'b1, 8'h44, 16'h0C00, 16'h0000, 1'b0);
      acc(1'b0, 8'h44, 16'h0000, 16'h0300, 1'b0);
      acc(1'b1, 8'h54, 16'h0704, 16'h0000, 1'b0);
      acc(1'b0, 8'h54, 16'h0000, 16'h0004, 1'b0);
      acc(1'b1, 8'h54, 16'hF704, 16'h0000, 1'b0);
      acc(1'b0, 8'h54, 16'h0000, 16'hF004, 1'b0);
      chk({24'h0, compare_output_mode[5:0], compare_preload_enable[1:0]}, 32'hE2);
      acc(1'b1, 8'h50, 16'h0300, 16'h0000, 1'b0);
      acc(1'b0, 8'h50, 16'h0000, 16'h0200, 1'b0);
      complete_run;
   end
endmodule // timer_break_deadtime_dma_burst_tb
